// ===== hw/processor_bus_error_reporter.v
// Processor-bus error detection, flagging, logging and interrupt
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "bus_err_consts.vh"
module processor_bus_error_reporter (
    input  wire                  pclk,
    input  wire                  presetn,
    // APB register port
    input  wire                  psel,
    input  wire                  penable,
    input  wire                  pwrite,
    input  wire [`ADDR_W-1:0]    paddr,
    input  wire [31:0]           pwdata,
    output reg  [31:0]           prdata,
    output reg                   pready,
    output reg                   pslverr,
    // Slave side, from the bus slave logic on pclk
    input  wire                  slv_valid,
    input  wire [1:0]            slv_dest,
    input  wire                  slv_write,
    input  wire                  slv_special_space,
    input  wire                  slv_burst,
    input  wire                  slv_unaligned,
    input  wire                  slv_addr_par_err,
    input  wire                  slv_data_par_err,
    input  wire [`TT_W-1:0]      transfer_type_lines,
    input  wire [`TSIZ_W-1:0]    transfer_size_lines,
    input  wire [31:0]           bus_address_lines,
    input  wire                  slv_read_err,
    input  wire                  slv_read_return,
    // Master side, from the bus master logic on pclk
    input  wire                  mst_busy,
    input  wire                  mst_done,
    input  wire [1:0]            mst_source,
    input  wire                  mst_write,
    input  wire                  mst_data_par_err,
    input  wire                  mst_retry_expired,
    input  wire [`TT_W-1:0]      mst_type_lines,
    input  wire [`TSIZ_W-1:0]    mst_size_lines,
    input  wire [31:0]           mst_address_lines,
    // Open-drain transfer error acknowledge pin, active low
    input  wire                  transfer_error_ack_n_in,
    output reg                   transfer_error_ack_n_out,
    output reg                   transfer_error_ack_oe,
    // Slave decisions and interrupt
    output reg                   slv_claim,
    output reg                   slv_forward,
    output reg                   irq
);

    ////////////////////////////////////////////////////////////////////////
    // Registers and wires

    reg  [`ST_W-1:0]   error_int_status_reg_r;
    reg  [`ST_W-1:0]   error_int_mask_r;
    reg  [`MISC_W-1:0] bus_misc_control_reg_r;
    reg  [`TT_W-1:0]   log_tt_r;
    reg  [`TSIZ_W-1:0] log_tsiz_r;
    reg                log_master_r;
    reg                error_log_status_bit_r;
    reg  [31:0]        bus_address_error_log_r;
    reg                read_err_pending_r;
    reg                tea_low_d_r;
    reg  [`ST_W-1:0]   status_set;
    reg  [`ST_W-1:0]   status_nxt;
    reg  [31:0]        rdata_nxt;
    reg                addr_hit;
    wire               tea_low;
    wire               tea_low_n_sync;
    wire               wr_en;
    wire               xfer_err_ack_enable;
    wire               address_retry_enable;
    wire               little_end;
    wire               slv_apar;
    wire               slv_dpar;
    wire               slv_illegal;
    wire               slv_special;
    wire               mst_rd_par;
    wire               mst_tea;
    wire               mst_retry;
    wire               slv_any_err;
    wire               mst_any_err;
    wire               rd_err_now;
    wire               rd_err_late;

    ////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // One-hot of a port code: bit0 PCI-1, bit1 PCI-2, bit2 local
    function [2:0] port_onehot;
        input [1:0] code;
        begin
            case (code)
                `PORT_PCI1:  port_onehot = 3'h1;
                `PORT_PCI2:  port_onehot = 3'h2;
                `PORT_LOCAL: port_onehot = 3'h4;
                default:     port_onehot = 3'h0;
            endcase
        end
    endfunction

    // Registers share the PCI-1 flags on the slave side
    function [1:0] slave_side;
        input [1:0] dest;
        begin
            slave_side = (dest == `PORT_PCI2) ? 2'h2 : 2'h1;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser for the incoming transfer error acknowledge

    sync_two_flop #(
        .WIDTH   (1),
        .RST_VAL (1'b1)
    ) u_tea_sync (
        .clk      (pclk),
        .rst_n    (presetn),
        .async_in (transfer_error_ack_n_in),
        .sync_out (tea_low_n_sync)
    );
    assign tea_low = ~tea_low_n_sync;

    ////////////////////////////////////////////////////////////////////////
    // Error classification

    assign xfer_err_ack_enable     = bus_misc_control_reg_r[`MISC_XFER_ERR_ACK_ENABLE];
    assign address_retry_enable   = bus_misc_control_reg_r[`MISC_ADDRESS_RETRY_ENABLE];
    assign little_end = bus_misc_control_reg_r[`MISC_LITTLE_END];

    // Slave checks every claimed cycle, address parity first
    assign slv_apar    = slv_valid & slv_addr_par_err;
    assign slv_dpar    = slv_valid & ~slv_apar & slv_write & slv_data_par_err;
    assign slv_special = (slv_dest == `PORT_LOCAL) | slv_special_space;
    assign slv_illegal = slv_valid & ~slv_apar &
                         ((little_end & slv_unaligned) |
                          (slv_special & ((transfer_size_lines > `MAX_SINGLE_BYTES) |
                                          slv_burst)));
    // Master checks every completed transfer; local-source retries are excluded
    assign mst_rd_par  = mst_done & ~mst_write & mst_data_par_err;
    assign mst_tea     = mst_busy & tea_low & ~tea_low_d_r;
    assign mst_retry   = mst_done & mst_retry_expired &
                         (mst_source != `PORT_LOCAL);
    assign slv_any_err = slv_apar | slv_dpar | slv_illegal;
    assign mst_any_err = mst_rd_par | mst_tea | mst_retry;

    // Read error reported now, or when the requester returns
    assign rd_err_now  = slv_read_err & ~address_retry_enable;
    assign rd_err_late = slv_read_return & read_err_pending_r;

    ////////////////////////////////////////////////////////////////////////
    // Status flag set terms
    wire [1:0] dest_side = slave_side(slv_dest);
    wire [2:0] src_port  = port_onehot(mst_source);

    always @* begin
        status_set = {`ST_W{1'b0}};
        status_set[`ST_SLV_APAR] = slv_apar;
        // Per destination on the slave side
        status_set[`ST_PCI1_DPAR] = slv_dpar & dest_side[0];
        status_set[`ST_PCI2_DPAR] = slv_dpar & dest_side[1];
        status_set[`ST_PCI1_ERR]  = slv_illegal & dest_side[0];
        status_set[`ST_PCI2_ERR]  = slv_illegal & dest_side[1];
        // Per source on the master side
        status_set[`ST_PCI1_DPAR]  = status_set[`ST_PCI1_DPAR] |
                                     (mst_rd_par & src_port[0]);
        status_set[`ST_PCI2_DPAR]  = status_set[`ST_PCI2_DPAR] |
                                     (mst_rd_par & src_port[1]);
        status_set[`ST_LOCAL_DPAR] = mst_rd_par & src_port[2];
        status_set[`ST_PCI1_ERR]   = status_set[`ST_PCI1_ERR] |
                                     (mst_tea & src_port[0]);
        status_set[`ST_PCI2_ERR]   = status_set[`ST_PCI2_ERR] |
                                     (mst_tea & src_port[1]);
        status_set[`ST_LOCAL_ERR]  = mst_tea & src_port[2];
        status_set[`ST_PCI1_RETRY] = mst_retry & src_port[0];
        status_set[`ST_PCI2_RETRY] = mst_retry & src_port[1];
    end

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    assign wr_en = psel & penable & pready & pwrite;

    // Write-one-to-clear, with a new event winning over the clear
    always @* begin
        status_nxt = error_int_status_reg_r;
        if (wr_en && paddr == `OFS_INT_STATUS) begin
            status_nxt = status_nxt & ~pwdata[`ST_W-1:0];
        end
        status_nxt = status_nxt | status_set;
    end

    // Read mux; unmapped addresses read zero with an error answer
    always @* begin
        rdata_nxt = 32'h0000_0000;
        addr_hit  = 1'b1;
        case (paddr)
            `OFS_INT_STATUS:   rdata_nxt[`ST_W-1:0] = error_int_status_reg_r;
            `OFS_INT_MASK:     rdata_nxt[`ST_W-1:0] = error_int_mask_r;
            `OFS_MISC_CTRL:    rdata_nxt[`MISC_W-1:0] = bus_misc_control_reg_r;
            `OFS_ERR_CTRL_LOG: begin
                rdata_nxt[`LOG_TT_LSB +: `TT_W]     = log_tt_r;
                rdata_nxt[`LOG_TSIZ_LSB +: `TSIZ_W] = log_tsiz_r;
                rdata_nxt[`LOG_MASTER_BIT]          = log_master_r;
                rdata_nxt[`LOG_ES_BIT]              = error_log_status_bit_r;
            end
            `OFS_ADDR_ERR_LOG: rdata_nxt = bus_address_error_log_r;
            default:           addr_hit = 1'b0;
        endcase
    end

    // No wait state: answer in the first access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_hit;
            prdata  <= (psel & ~penable & ~pwrite) ? rdata_nxt : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control, status and interrupt

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            error_int_status_reg_r <= {`ST_W{1'b0}};
            error_int_mask_r       <= {`ST_W{1'b0}};
            bus_misc_control_reg_r <= `MISC_RESET;
            irq                    <= 1'b0;
        end else begin
            error_int_status_reg_r <= status_nxt;
            if (wr_en && paddr == `OFS_INT_MASK) begin
                error_int_mask_r <= pwdata[`ST_W-1:0];
            end
            if (wr_en && paddr == `OFS_MISC_CTRL) begin
                bus_misc_control_reg_r <= pwdata[`MISC_W-1:0];
            end
            irq <= |(status_nxt & error_int_mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error logs: capture on any flagged error while the log is armed

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            log_tt_r                <= {`TT_W{1'b0}};
            log_tsiz_r              <= {`TSIZ_W{1'b0}};
            log_master_r            <= 1'b0;
            error_log_status_bit_r  <= 1'b0;
            bus_address_error_log_r <= 32'h0000_0000;
        end else if (!error_log_status_bit_r && slv_any_err) begin
            log_tt_r                <= transfer_type_lines;
            log_tsiz_r              <= transfer_size_lines;
            log_master_r            <= 1'b0;
            error_log_status_bit_r  <= 1'b1;
            bus_address_error_log_r <= bus_address_lines;
        end else if (!error_log_status_bit_r && mst_any_err) begin
            log_tt_r                <= mst_type_lines;
            log_tsiz_r              <= mst_size_lines;
            log_master_r            <= 1'b1;
            error_log_status_bit_r  <= 1'b1;
            bus_address_error_log_r <= mst_address_lines;
        end else if (wr_en && paddr == `OFS_ERR_CTRL_LOG &&
                     pwdata[`LOG_ES_BIT]) begin
            error_log_status_bit_r  <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Slave response and transfer error acknowledge pin

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_err_pending_r       <= 1'b0;
            tea_low_d_r              <= 1'b0;
            slv_claim                <= 1'b0;
            slv_forward              <= 1'b0;
            transfer_error_ack_n_out <= 1'b0;
            transfer_error_ack_oe    <= 1'b0;
        end else begin
            tea_low_d_r <= tea_low;
            // Latched read error waits for the requester, new error wins
            if (slv_read_err && address_retry_enable) begin
                read_err_pending_r <= 1'b1;
            end else if (slv_read_return) begin
                read_err_pending_r <= 1'b0;
            end
            slv_claim   <= slv_valid & ~slv_apar;
            // Data parity errors still forward; illegal ones never do
            slv_forward <= slv_valid & ~slv_apar & ~slv_illegal;
            transfer_error_ack_n_out <= 1'b0;
            transfer_error_ack_oe    <= xfer_err_ack_enable &
                                        (slv_illegal | rd_err_now | rd_err_late);
        end
    end

endmodule // processor_bus_error_reporter
`default_nettype wire

// ===== hw/bus_err_consts.vh
// Constants for the processor-bus error reporter
// Function
// - Master and slave check every transaction
// - Every error sets an interrupt status bit; slave read errors set none
// - Master errors flagged per source port
// - Slave errors flagged per destination port
// - Transfer error ack only when enabled
// - Log type, size and address on error
// - Log every detected error case; slave read errors are not logged
// - Slave address parity sets address flag
// - Slave write data parity flag by destination
// - Illegal slave accesses flag destination error
// - Master read parity flagged per PCI side
// - Local DMA read parity sets local flag
// - Received transfer error ack flags source
// - Retry expiry sets retry flag per side
// - Illegal transactions never forwarded, flags still set
// - Read error now or on requester return
// - Address parity: no claim; data parity: proceed
`ifndef BUS_ERR_CONSTS_VH
`define BUS_ERR_CONSTS_VH

// Register byte offsets
`define OFS_INT_STATUS   12'h000
`define OFS_INT_MASK     12'h004
`define OFS_MISC_CTRL    12'h008
`define OFS_ERR_CTRL_LOG 12'h00c
`define OFS_ADDR_ERR_LOG 12'h010
`define ADDR_W           12

// Status flag positions
`define ST_W             9
`define ST_SLV_APAR      0
`define ST_PCI1_DPAR     1
`define ST_PCI2_DPAR     2
`define ST_LOCAL_DPAR    3
`define ST_PCI1_ERR      4
`define ST_PCI2_ERR      5
`define ST_LOCAL_ERR     6
`define ST_PCI1_RETRY    7
`define ST_PCI2_RETRY    8

// Misc control bits
`define MISC_XFER_ERR_ACK_ENABLE      0
`define MISC_ADDRESS_RETRY_ENABLE    1
`define MISC_LITTLE_END  2
`define MISC_W           3
`define MISC_RESET       3'h1

// Error control log fields
`define LOG_TT_LSB       0
`define LOG_TSIZ_LSB     8
`define LOG_MASTER_BIT   30
`define LOG_ES_BIT       31
`define TT_W             5
`define TSIZ_W           3

// Port codes for destination and source
`define PORT_PCI1        2'h0
`define PORT_PCI2        2'h1
`define PORT_LOCAL       2'h2

// Largest single-beat size for registers and PCI special space
`define MAX_SINGLE_BYTES 3'h4

`endif

// ===== hw/sync_two_flop.v
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module sync_two_flop #(
    parameter WIDTH    = 1,
    parameter RST_VAL  = 1'b1
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    ////////////////////////////////////////////////////////////////////////
    // Each bit passes two stages; only the second stage is read
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg meta_r;
            reg stable_r;
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_r   <= RST_VAL;
                    stable_r <= RST_VAL;
                end else begin
                    meta_r   <= async_in[i];
                    stable_r <= meta_r;
                end
            end
            assign sync_out[i] = stable_r;
        end
    endgenerate
endmodule // sync_two_flop
`default_nettype wire

// ===== verif/bus_err_props.sv
// Port-level assertions for the processor-bus error reporter
`timescale 1ns/100ps
`default_nettype none
`include "bus_err_consts.vh"
module bus_err_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic        slv_valid,
    input wire logic [1:0]  slv_dest,
    input wire logic        slv_special_space,
    input wire logic        slv_burst,
    input wire logic        slv_unaligned,
    input wire logic        slv_addr_par_err,
    input wire logic [2:0]  transfer_size_lines,
    input wire logic        slv_read_err,
    input wire logic        slv_read_return,
    input wire logic        transfer_error_ack_n_out,
    input wire logic        transfer_error_ack_oe,
    input wire logic        slv_claim,
    input wire logic        slv_forward
);
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////
    // Request shapes
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_slv_ok;
        slv_valid && !slv_addr_par_err;
    endsequence
    sequence s_illegal;
        slv_valid && (slv_dest == `PORT_LOCAL || slv_special_space)
            && (slv_burst || transfer_size_lines > `MAX_SINGLE_BYTES);
    endsequence
    ////////////////////////////////////////
    // Properties
    property p_ready_next; s_setup |=> pready; endproperty
    property p_refuse_zero; pready && pslverr |-> prdata == 32'h0; endproperty
    property p_claim; s_slv_ok |=> slv_claim; endproperty
    property p_no_claim; slv_valid && slv_addr_par_err |=> !slv_claim && !slv_forward; endproperty
    property p_mem_forward;
        s_slv_ok ##0 (!slv_special_space && slv_dest != `PORT_LOCAL && !slv_unaligned)
            |=> slv_forward;
    endproperty
    property p_illegal_held; s_illegal |=> !slv_forward; endproperty
    property p_tea_low; transfer_error_ack_oe |-> !transfer_error_ack_n_out; endproperty
    property p_tea_cause;
        transfer_error_ack_oe |-> $past(slv_valid || slv_read_err || slv_read_return);
    endproperty
    ////////////////////////////////////////
    // Checks
    a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
    a_refuse_zero: assert property (p_refuse_zero) else $error("refused read not zero");
    a_claim: assert property (p_claim) else $error("clean cycle not claimed");
    a_no_claim: assert property (p_no_claim) else $error("bad address claimed");
    a_mem_forward: assert property (p_mem_forward) else $error("not forwarded");
    a_illegal_held: assert property (p_illegal_held) else $error("illegal forwarded");
    a_tea_low: assert property (p_tea_low) else $error("ack pin driven high");
    a_tea_cause: assert property (p_tea_cause) else $error("ack without cause");
endmodule // bus_err_props
bind processor_bus_error_reporter bus_err_props i_bus_err_props (
    .pclk, .presetn, .psel, .penable, .pready, .pslverr, .prdata, .slv_valid, .slv_dest,
    .slv_special_space, .slv_burst, .slv_unaligned, .slv_addr_par_err, .transfer_size_lines,
    .slv_read_err, .slv_read_return, .transfer_error_ack_n_out, .transfer_error_ack_oe,
    .slv_claim, .slv_forward
);
`default_nettype wire

// ===== verif/bus_agent_model.sv
// Processor-bus masters and slaves facing the error reporter
`timescale 1ns/100ps
`default_nettype none
module bus_agent_model (
    input  wire logic        pclk,
    output var  logic        slv_valid, slv_write, slv_special_space, slv_burst,
    output var  logic        slv_unaligned, slv_addr_par_err, slv_data_par_err,
    output var  logic        slv_read_err, slv_read_return, tea_pull,
    output var  logic [1:0]  slv_dest, mst_source,
    output var  logic [4:0]  transfer_type_lines, mst_type_lines,
    output var  logic [2:0]  transfer_size_lines, mst_size_lines,
    output var  logic [31:0] bus_address_lines, mst_address_lines,
    output var  logic        mst_busy, mst_done, mst_write, mst_data_par_err, mst_retry_expired
);
    // Quiet bus at time zero
    initial begin
        {slv_valid, slv_read_err, slv_read_return, tea_pull, mst_busy, mst_done} = 6'h0;
    end
    // One transfer: 0 slave, 1 master, 2 master ended by error ack, 3 read error or return
    task automatic ev(input logic [2:0] kd, input logic [1:0] d, input logic [4:0] f,
                      input logic [2:0] sz, input logic [31:0] a);
        @(posedge pclk);
        if (kd == 3'h3) begin
            slv_read_err <= ~f[0];
            slv_read_return <= f[0];
            @(posedge pclk);
            slv_read_err <= 1'b0;
            slv_read_return <= 1'b0;
        end else if (kd == 3'h0) begin
            slv_valid <= 1'b1;
            slv_dest <= d;
            slv_write <= ~f[1];
            {slv_special_space, slv_burst, slv_unaligned, slv_addr_par_err, slv_data_par_err} <= f;
            transfer_type_lines <= {d, sz};
            transfer_size_lines <= sz;
            bus_address_lines <= a;
            @(posedge pclk);
            slv_valid <= 1'b0;
            {slv_special_space, slv_burst, slv_unaligned, slv_addr_par_err, slv_data_par_err} <= ~f;
            transfer_type_lines <= ~{d, sz};
            bus_address_lines <= ~a;
        end else begin
            mst_busy <= 1'b1;
            mst_source <= d;
            mst_write <= f[1];
            mst_type_lines <= {d, sz};
            mst_size_lines <= sz;
            mst_address_lines <= a;
            tea_pull <= kd[1];
            repeat (4) @(posedge pclk);
            tea_pull <= 1'b0;
            mst_done <= 1'b1;
            {mst_retry_expired, mst_data_par_err} <= f[1:0];
            @(posedge pclk);
            mst_done <= 1'b0;
            mst_busy <= 1'b0;
            {mst_retry_expired, mst_data_par_err} <= ~f[1:0];
            mst_address_lines <= ~a;
        end
    endtask
endmodule // bus_agent_model
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the processor-bus error reporter
`timescale 1ns/100ps
`default_nettype none
`include "bus_err_consts.vh"
module tb_top;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, rd, er, a;
    wire  [31:0] prdata, bus_address_lines, mst_address_lines;
    wire         pready, pslverr, irq, slv_claim, slv_forward, tea_pull, transfer_error_ack_n_in;
    wire         transfer_error_ack_n_out, transfer_error_ack_oe, slv_valid, slv_write;
    wire         slv_special_space, slv_burst, slv_unaligned, slv_addr_par_err, slv_data_par_err;
    wire         slv_read_err, slv_read_return, mst_busy, mst_done, mst_write;
    wire         mst_data_par_err, mst_retry_expired;
    wire  [1:0]  slv_dest, mst_source;
    wire  [4:0]  transfer_type_lines, mst_type_lines;
    wire  [2:0]  transfer_size_lines, mst_size_lines;
    int          fails = 0, comparisons = 0, tea_seen = 0, cycles = 0, t0;
    // Case table: kind, port, flags, size, status bit
    logic [2:0]  kd [11] = '{0, 0, 0, 1, 1, 0, 0, 2, 1, 1, 0};
    logic [1:0]  dd [11] = '{0, 2, 1, 2, 1, 2, 1, 2, 0, 1, 0};
    logic [4:0]  ff [11] = '{2, 1, 1, 1, 1, 8, 4, 0, 2, 2, 16};
    logic [2:0]  ss [11] = '{4, 4, 4, 4, 4, 4, 2, 4, 4, 4, 5};
    int          bt [11] = '{0, 1, 2, 3, 2, 4, 5, 6, 7, 8, 4};
    ////////////////////////////////////////
    // Open-drain ack pin with pull-up
    assign transfer_error_ack_n_in =
        ~((transfer_error_ack_oe & ~transfer_error_ack_n_out) | tea_pull);
    processor_bus_error_reporter i_processor_bus_error_reporter (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .slv_valid, .slv_dest, .slv_write, .slv_special_space, .slv_burst, .slv_unaligned,
        .slv_addr_par_err, .slv_data_par_err, .transfer_type_lines, .transfer_size_lines,
        .bus_address_lines, .slv_read_err, .slv_read_return, .mst_busy, .mst_done, .mst_source,
        .mst_write, .mst_data_par_err, .mst_retry_expired, .mst_type_lines, .mst_size_lines,
        .mst_address_lines, .transfer_error_ack_n_in, .transfer_error_ack_n_out,
        .transfer_error_ack_oe, .slv_claim, .slv_forward, .irq);
    bus_agent_model i_bus_agent_model (
        .pclk, .slv_valid, .slv_write, .slv_special_space, .slv_burst, .slv_unaligned,
        .slv_addr_par_err, .slv_data_par_err, .slv_read_err, .slv_read_return, .tea_pull,
        .slv_dest, .mst_source, .transfer_type_lines, .mst_type_lines, .transfer_size_lines,
        .mst_size_lines, .bus_address_lines, .mst_address_lines, .mst_busy, .mst_done,
        .mst_write, .mst_data_par_err, .mst_retry_expired);
    ////////////////////////////////////////
    // Clock
    initial begin
        forever #20 pclk = ~pclk;
    end
    // Ack pulse counter and hang guard
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (transfer_error_ack_oe === 1'b1) begin
            tea_seen <= tea_seen + 1;
        end
        if (cycles == 5000) begin
            fails = fails + 1;
            complete_run();
        end
    end
    ////////////////////////////////////////
    // Verdict
    task automatic complete_run();
        if (fails == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Compare one value
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer, waits for pready
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = {31'h0, pslverr};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        apb(1'b1, ad, d);
    endtask
    task automatic rdc(input logic [11:0] ad, input logic [31:0] exp);
        apb(1'b0, ad, 32'h0);
        chk(rd, exp);
    endtask
    ////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`OFS_INT_STATUS, 32'h0);
        rdc(`OFS_INT_MASK, 32'h0);
        rdc(`OFS_MISC_CTRL, 32'h1);
        rdc(`OFS_ERR_CTRL_LOG, 32'h0);
        rdc(12'h014, 32'h0);
        chk(er, 32'h1);
        wr(`OFS_INT_MASK, 32'h1ff);
        wr(`OFS_MISC_CTRL, 32'h5);
        rdc(`OFS_MISC_CTRL, 32'h5);
        for (int k = 0; k < 11; k++) begin
            a = 32'h1000_0000 + k * 32'h0000_0110;
            i_bus_agent_model.ev(kd[k], dd[k], ff[k], ss[k], a);
            repeat (4) @(posedge pclk);
            chk({31'h0, irq}, 32'h1);
            rdc(`OFS_INT_STATUS, 32'h1 << bt[k]);
            rdc(`OFS_ERR_CTRL_LOG,
                {1'b1, kd[k] != 3'h0, 19'h0, ss[k], 3'h0, dd[k], ss[k]});
            rdc(`OFS_ADDR_ERR_LOG, a);
            wr(`OFS_ERR_CTRL_LOG, 32'h8000_0000);
            wr(`OFS_INT_STATUS, 32'h1ff);
            repeat (2) @(posedge pclk);
            chk({31'h0, irq}, 32'h0);
        end
        chk(tea_seen, 32'd3);
        wr(`OFS_MISC_CTRL, 32'h4);
        t0 = tea_seen;
        i_bus_agent_model.ev(3'h0, 2'h2, 5'h08, 3'h4, 32'h0);
        repeat (4) @(posedge pclk);
        rdc(`OFS_INT_STATUS, 32'h10);
        chk(tea_seen, t0);
        wr(`OFS_INT_STATUS, 32'h1ff);
        wr(`OFS_MISC_CTRL, 32'h1);
        i_bus_agent_model.ev(3'h3, 2'h0, 5'h00, 3'h0, 32'h0);
        repeat (4) @(posedge pclk);
        chk(tea_seen, t0 + 1);
        wr(`OFS_MISC_CTRL, 32'h3);
        i_bus_agent_model.ev(3'h3, 2'h0, 5'h00, 3'h0, 32'h0);
        repeat (4) @(posedge pclk);
        chk(tea_seen, t0 + 1);
        i_bus_agent_model.ev(3'h3, 2'h0, 5'h01, 3'h0, 32'h0);
        repeat (4) @(posedge pclk);
        chk(tea_seen, t0 + 2);
        wr(`OFS_INT_MASK, 32'h0);
        i_bus_agent_model.ev(3'h0, 2'h0, 5'h02, 3'h4, 32'h0);
        i_bus_agent_model.ev(3'h1, 2'h2, 5'h01, 3'h4, 32'h0);
        repeat (4) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        wr(`OFS_INT_STATUS, 32'h1);
        rdc(`OFS_INT_STATUS, 32'h8);
        wr(`OFS_INT_MASK, 32'h8);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
